// >>> rspe_exec.sv
// Execution datapath for rotates, literal subtract and power-down
`timescale 1ns/1ns
`default_nettype none
module rspe_exec #(
  parameter int DEPTH = rspe_pkg::FILE_DEPTH
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rstn,
  input  wire rspe_pkg::rspe_instr_type      instr,
  input  wire logic                          instrValid,
  input  wire logic                          wakeUp,
  output var  logic [rspe_pkg::DATA_W-1:0]   accumulator,
  output var  rspe_pkg::rspe_status_type     status,
  output var  logic [rspe_pkg::DATA_W-1:0]   watchdog_counter,
  output var  logic [rspe_pkg::DATA_W-1:0]   watchdogPrescaler,
  output var  logic                          oscillatorRun,
  output var  logic                          sleeping,
  output var  logic [rspe_pkg::DATA_W-1:0]   fileReadData
);

  // Elaboration-time check of the file size
  if (DEPTH < 1 || DEPTH > rspe_pkg::FILE_DEPTH) begin : g_depthCheck
    $error("rspe_exec: DEPTH must lie in 1..128");
  end

  logic [rspe_pkg::DATA_W-1:0] fileMem [DEPTH];
  rspe_pkg::rspe_state_type    state;
  logic                        wakeSync1;
  logic                        wakeSync2;
  logic [rspe_pkg::DATA_W-1:0] operand;
  logic [rspe_pkg::DATA_W-1:0] next_result;
  logic                        next_carry;
  logic                        execute;
  logic                        downTaken;
  logic                        next_sleep;
  logic                        writeFile;

  // Borrow-free test used for both carry and nibble carry
  function automatic logic noBorrow(input logic [7:0] minuend, input logic [7:0] subtrahend);
    return subtrahend <= minuend;
  endfunction

  // Both rotates share destination and flag handling
  function automatic logic isRotate(input rspe_pkg::rspe_op_type op);
    return op == rspe_pkg::OP_ROTATE_LEFT_VIA_CARRY || op == rspe_pkg::OP_ROTATE_RIGHT_VIA_CARRY;
  endfunction

  // Wake request is a pin, so it is synchronised first
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wakeSync1 <= 1'b0;
      wakeSync2 <= 1'b0;
    end else begin
      wakeSync1 <= wakeUp;
      wakeSync2 <= wakeSync1;
    end
  end

  // Nothing executes while asleep: execute is gated on ST_RUN, so instructions presented during sleep are ignored
  assign execute = instrValid && (state == rspe_pkg::ST_RUN);
  assign operand = fileMem[instr.fileAddr];

  // Decoded once so state, indications and watchdog cannot disagree
  assign downTaken  = execute && (instr.op == rspe_pkg::OP_POWER_DOWN);
  assign next_sleep = downTaken || (state == rspe_pkg::ST_SLEEP && !wakeSync2);
  assign writeFile  = execute && instr.dest == rspe_pkg::DEST_FILE && isRotate(instr.op);

  // Rotate and subtract results
  always_comb begin
    next_result = operand;
    next_carry  = status.carry;
    case (instr.op)
      rspe_pkg::OP_ROTATE_LEFT_VIA_CARRY: begin
        next_result = {operand[rspe_pkg::MSB_POS-1:0], status.carry};
        next_carry  = operand[rspe_pkg::MSB_POS];
      end
      rspe_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin
        next_result = {status.carry, operand[rspe_pkg::MSB_POS:1]};
        next_carry  = operand[0];
      end
      rspe_pkg::OP_LITERAL_MINUS_ACCUMULATOR: begin
        next_result = instr.literal - accumulator;
        next_carry  = noBorrow(instr.literal, accumulator);
      end
      default: begin
        next_result = operand;
        next_carry  = status.carry;
      end
    endcase
  end

  // Run and sleep state; a wake request resumes execution
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state <= rspe_pkg::ST_RUN;
    end else begin
      case (state)
        rspe_pkg::ST_RUN: begin
          if (downTaken) begin
            state <= rspe_pkg::ST_SLEEP;
          end
        end
        rspe_pkg::ST_SLEEP: begin
          if (wakeSync2) begin
            state <= rspe_pkg::ST_RUN;
          end
        end
        default: state <= rspe_pkg::ST_RUN;
      endcase
    end
  end

  // Run indications mirror the state, registered for clean outputs
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sleeping      <= 1'b0;
      oscillatorRun <= 1'b1;
    end else begin
      sleeping      <= next_sleep;
      oscillatorRun <= !next_sleep;
    end
  end

  // Accumulator updates, one cycle per instruction
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      accumulator <= rspe_pkg::ACC_RESET;
    end else if (execute) begin
      case (instr.op)
        rspe_pkg::OP_ROTATE_LEFT_VIA_CARRY,
        rspe_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin
          if (instr.dest == rspe_pkg::DEST_ACC) begin
            accumulator <= next_result;
          end
        end
        rspe_pkg::OP_LITERAL_MINUS_ACCUMULATOR: accumulator <= next_result;
        default: accumulator <= accumulator;
      endcase
    end
  end

  // File register write-back; no reset so it can map to memory
  always_ff @(posedge clk_sys) begin
    if (writeFile) begin
      fileMem[instr.fileAddr] <= next_result;
    end
  end

  // Registered read port so the file can be observed
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fileReadData <= rspe_pkg::FILE_RESET;
    end else begin
      fileReadData <= operand;
    end
  end

  // Status flags; rotates leave everything but carry alone
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      status <= rspe_pkg::STATUS_RESET;
    end else if (execute) begin
      case (instr.op)
        rspe_pkg::OP_ROTATE_LEFT_VIA_CARRY,
        rspe_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin
          status.carry <= next_carry;
        end
        rspe_pkg::OP_LITERAL_MINUS_ACCUMULATOR: begin
          status.carry       <= next_carry;
          status.nibbleCarry <= noBorrow({4'h0, instr.literal[rspe_pkg::LOW_NIB_MSB:0]},
                                         {4'h0, accumulator[rspe_pkg::LOW_NIB_MSB:0]});
          status.zero        <= (next_result == 8'h00);
        end
        rspe_pkg::OP_POWER_DOWN: begin
          status.powerDownFlag <= 1'b0;
          status.timeoutFlag   <= 1'b1;
        end
        default: status <= status;
      endcase
    end
  end

  // Stand-in prescaler: counts every awake cycle, power-down clears it
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      watchdogPrescaler <= rspe_pkg::PRESC_CLEAR;
    end else if (downTaken) begin
      watchdogPrescaler <= rspe_pkg::PRESC_CLEAR;
    end else if (state == rspe_pkg::ST_RUN) begin
      watchdogPrescaler <= watchdogPrescaler + 8'h01;
    end
  end

  // Stand-in counter: steps on prescaler wrap, power-down clears it
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      watchdog_counter <= rspe_pkg::WDOG_CLEAR;
    end else if (downTaken) begin
      watchdog_counter <= rspe_pkg::WDOG_CLEAR;
    end else if (state == rspe_pkg::ST_RUN && watchdogPrescaler == rspe_pkg::PRESC_MAX &&
                 watchdog_counter != rspe_pkg::WDOG_MAX) begin
      watchdog_counter <= watchdog_counter + 8'h01; // Saturates; trip handling lives elsewhere
    end
  end

endmodule // rspe_exec
`default_nettype wire

// >>> rspe_pkg.sv
// Package for the rotate, subtract and power-down execution datapath
`default_nettype none
package rspe_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam int MSB_POS = 7;
  localparam int LOW_NIB_MSB = 3;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic [7:0] WDOG_CLEAR = 8'h00;
  localparam logic [7:0] WDOG_MAX = 8'hff;
  localparam logic [7:0] PRESC_CLEAR = 8'h00;
  localparam logic [7:0] PRESC_MAX = 8'hff;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Operation codes presented on the instruction port
  typedef enum logic [2:0] {
    OP_NONE                       = 3'b000,
    OP_ROTATE_LEFT_VIA_CARRY      = 3'b001,
    OP_ROTATE_RIGHT_VIA_CARRY     = 3'b010,
    OP_LITERAL_MINUS_ACCUMULATOR  = 3'b011,
    OP_POWER_DOWN                 = 3'b100
  } rspe_op_type;

  // Core run state
  typedef enum logic [0:0] {
    ST_RUN   = 1'b0,
    ST_SLEEP = 1'b1
  } rspe_state_type;

  // One decoded instruction word
  typedef struct packed {
    rspe_op_type       op;
    logic [ADDR_W-1:0] fileAddr;
    logic              dest;
    logic [DATA_W-1:0] literal;
  } rspe_instr_type;

  // Status bits kept by the block
  typedef struct packed {
    logic carry;
    logic nibbleCarry;
    logic zero;
    logic timeoutFlag;
    logic powerDownFlag;
  } rspe_status_type;

  localparam rspe_status_type STATUS_RESET = '{carry: 1'b0, nibbleCarry: 1'b0, zero: 1'b0,
                                                timeoutFlag: 1'b1, powerDownFlag: 1'b1};

endpackage
`default_nettype wire

// >>> rspe_exec_properties.sv
// Checker for the execution datapath ports
`timescale 1ns/1ns
`default_nettype none
module rspe_exec_properties (
  input wire logic                      clk_sys,
  input wire logic                      rstn,
  input wire rspe_pkg::rspe_instr_type  instr,
  input wire logic                      instrValid,
  input wire logic                      wakeUp,
  input wire logic [7:0]                accumulator,
  input wire rspe_pkg::rspe_status_type status,
  input wire logic [7:0]                watchdog_counter,
  input wire logic [7:0]                watchdogPrescaler,
  input wire logic                      oscillatorRun,
  input wire logic                      sleeping,
  input wire logic [7:0]                fileReadData
);
  localparam rspe_pkg::rspe_op_type L = rspe_pkg::OP_ROTATE_LEFT_VIA_CARRY;
  localparam rspe_pkg::rspe_op_type R = rspe_pkg::OP_ROTATE_RIGHT_VIA_CARRY;
  localparam rspe_pkg::rspe_op_type S = rspe_pkg::OP_LITERAL_MINUS_ACCUMULATOR;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Instruction accepted while awake
  sequence s_op(rspe_pkg::rspe_op_type o, logic d);
    instrValid && !sleeping && instr.op == o && instr.dest == d;
  endsequence
  // Power-down taken, then the flags and the sleep state together
  sequence s_down;
    instrValid && !sleeping && instr.op == rspe_pkg::OP_POWER_DOWN;
  endsequence
  sequence s_asleep;
    !status.powerDownFlag && status.timeoutFlag && sleeping && !oscillatorRun;
  endsequence
  a_sub_result: assert property (s_op(S, instr.dest) |=>
    accumulator == $past(instr.literal) - $past(accumulator)) else $error("subtract result wrong");
  a_sub_flags: assert property (s_op(S, instr.dest) |=>
    status.carry == ($past(accumulator) <= $past(instr.literal))
    && status.nibbleCarry == ($past(accumulator[3:0]) <= $past(instr.literal[3:0]))) else $error("subtract carry wrong");
  a_sub_zero: assert property (s_op(S, instr.dest) |=>
    status.zero == (accumulator == 8'h00)) else $error("subtract zero wrong");
  a_down_flags: assert property (s_down |=> s_asleep) else $error("power-down flags wrong");
  a_down_watchdog: assert property (s_down |=>
    watchdog_counter == 8'h00 && watchdogPrescaler == 8'h00) else $error("watchdog not cleared");
  a_sleep_ignore: assert property (sleeping && instrValid |=>
    $stable(accumulator) && $stable(status)) else $error("instruction ran asleep");
  a_left_carry: assert property (s_op(L, 1'b0) |=>
    accumulator == {fileReadData[6:0], $past(status.carry)} && status.carry == fileReadData[7])
    else $error("rotate left result wrong");
  a_right_carry: assert property (s_op(R, 1'b0) |=>
    accumulator == {$past(status.carry), fileReadData[7:1]} && status.carry == fileReadData[0])
    else $error("rotate right result wrong");
  a_rot_file: assert property (s_op(L, 1'b1) or s_op(R, 1'b1) |=>
    $stable(accumulator)) else $error("rotate to file changed accumulator");
  a_rot_status: assert property (instrValid && !sleeping && (instr.op == L || instr.op == R) |=>
    $stable(status[3:0])) else $error("rotate changed other flags");
endmodule // rspe_exec_properties
bind rspe_exec rspe_exec_properties i_rspe_exec_properties (.clk_sys(clk_sys), .rstn(rstn), .instr(instr),
  .instrValid(instrValid), .wakeUp(wakeUp), .accumulator(accumulator), .status(status),
  .watchdog_counter(watchdog_counter), .watchdogPrescaler(watchdogPrescaler),
  .oscillatorRun(oscillatorRun), .sleeping(sleeping), .fileReadData(fileReadData));
`default_nettype wire

// >>> rspe_exec_bench.sv
// Self-checking bench for the execution datapath
`timescale 1ns/1ns
`default_nettype none
module rspe_exec_bench;
  localparam rspe_pkg::rspe_op_type L = rspe_pkg::OP_ROTATE_LEFT_VIA_CARRY;
  localparam rspe_pkg::rspe_op_type R = rspe_pkg::OP_ROTATE_RIGHT_VIA_CARRY;
  localparam rspe_pkg::rspe_op_type S = rspe_pkg::OP_LITERAL_MINUS_ACCUMULATOR;
  localparam rspe_pkg::rspe_op_type P = rspe_pkg::OP_POWER_DOWN;
  logic clk_sys = 1'b0, rstn = 1'b0, instrValid = 1'b0, wakeUp = 1'b0;
  logic osc, slp, mC = 1'b0, mDc = 1'b0, mZ = 1'b0, mTo = 1'b1, mPd = 1'b1, mSlp = 1'b0;
  logic [7:0] acc, wdc, wdp, frd, r, f, mAcc = 8'h00, mem [128];
  logic [7:0] tA [8] = '{8'h05, 8'h06, 8'h10, 8'h0f, 8'hff, 8'h00, 8'h80, 8'h3a};
  logic [7:0] tK [8] = '{8'h05, 8'h05, 8'h0f, 8'h10, 8'h00, 8'hff, 8'h7f, 8'hc4};
  rspe_pkg::rspe_instr_type  instr = '0;
  rspe_pkg::rspe_status_type st;
  int err_count = 0, num_checks = 0;
  rspe_exec i_rspe_exec (.clk_sys(clk_sys), .rstn(rstn), .instr(instr), .instrValid(instrValid),
    .wakeUp(wakeUp), .accumulator(acc), .status(st), .watchdog_counter(wdc),
    .watchdogPrescaler(wdp), .oscillatorRun(osc), .sleeping(slp), .fileReadData(frd));
  initial forever #4 clk_sys = ~clk_sys;
  // Unknown expectations (file not yet loaded) are skipped, not matched
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    if (!$isunknown(exp)) begin
      num_checks++;
      if (seen !== exp) begin
        err_count++;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // One instruction; valid stays up so calls run back to back
  task automatic ex(input rspe_pkg::rspe_op_type o, input logic [6:0] a, input logic d, input logic [7:0] k);
    instr = '{o, a, d, k};
    instrValid = 1'b1;
    @(posedge clk_sys);
    #1;
    f = mem[a];
    if (mSlp) r = 8'h00;
    else if (o == P) {mSlp, mPd, mTo} = 3'b101;
    else if (o == S) begin
      r = k - mAcc;
      {mC, mDc, mZ} = {mAcc <= k, mAcc[3:0] <= k[3:0], r == 8'h00};
      mAcc = r;
    end else if (o != rspe_pkg::OP_NONE) begin
      r = (o == L) ? {f[6:0], mC} : {mC, f[7:1]};
      mC = (o == L) ? f[7] : f[0];
      if (d) mem[a] = r;
      else mAcc = r;
    end
    chk(acc, mAcc);
    chk(8'(st), {3'b000, mC, mDc, mZ, mTo, mPd});
    chk({6'h00, slp, osc}, {6'h00, mSlp, !mSlp});
  endtask
  // Carry set through a subtract, since rotates load it only from file bits
  task automatic setc(input logic b);
    if (b) ex(S, 7'h00, 1'b0, 8'hff);
    else begin
      if (mAcc == 8'h00) ex(S, 7'h00, 1'b0, 8'h01);
      ex(S, 7'h00, 1'b0, 8'h00);
    end
  endtask
  // Fill a file byte by rotating known carries in
  task automatic ld(input logic [6:0] a, input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      setc(v[i]);
      ex(L, a, 1'b1, 8'h00);
    end
  endtask
  task automatic rd(input logic [6:0] a);
    instrValid = 1'b0;
    instr.fileAddr = a;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(frd, mem[a]);
  endtask
  task automatic close_out();
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #30000;
    err_count++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    chk(8'(st), 8'h03);
    ld(7'h00, 8'ha5);
    ld(7'h7f, 8'h3c);
    rd(7'h00);
    rd(7'h7f);
    setc(1'b1);
    ex(L, 7'h00, 1'b0, 8'h00);
    ex(R, 7'h7f, 1'b0, 8'h00);
    ex(R, 7'h7f, 1'b1, 8'h00);
    ex(L, 7'h00, 1'b1, 8'h00);
    ex(rspe_pkg::OP_NONE, 7'h00, 1'b0, 8'h77);
    rd(7'h7f);
    rd(7'h00);
    for (int i = 0; i < 8; i++) begin
      ex(S, 7'h00, 1'b0, tA[i] + mAcc);
      ex(S, 7'h00, 1'b0, tK[i]);
    end
    // Idle awake until the counter has stepped, so the clear is visible
    instrValid = 1'b0;
    for (int i = 0; i < 600 && wdc == 8'h00; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk({7'h00, wdc != 8'h00}, 8'h01);
    ex(P, 7'h00, 1'b0, 8'h00);
    chk(wdc, 8'h00);
    chk(wdp, 8'h00);
    ex(S, 7'h00, 1'b0, 8'h55);
    ex(L, 7'h00, 1'b0, 8'h00);
    instrValid = 1'b0;
    wakeUp = 1'b1;
    for (int i = 0; i < 20 && slp !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    wakeUp = 1'b0;
    mSlp = 1'b0;
    ex(S, 7'h00, 1'b0, 8'h10);
    close_out();
  end
endmodule // rspe_exec_bench
`default_nettype wire
